// *** hw/wdrc_defines.vh ***
// Constants for the watchdog and reset control block
`ifndef WDRC_DEFINES_VH
`define WDRC_DEFINES_VH

// Register byte offsets on the Avalon-MM slave
`define WDRC_OFF_WDT_CTRL      4'h0
`define WDRC_OFF_PIN_FUNC      4'h4
`define WDRC_OFF_CAUSE         4'h8
`define WDRC_OFF_STATUS        4'hc

// Watchdog control fields and codes
`define WDRC_KEY_MSB           7
`define WDRC_KEY_LSB           3
`define WDRC_SEL_MSB           2
`define WDRC_SEL_LSB           0
`define WDRC_KEY_DISABLE       5'h15
`define WDRC_KEY_ENABLE        5'h0a
`define WDRC_WDT_CTRL_RESET    8'h52

// Reset pin function codes
`define WDRC_PIN_PORT          8'h55
`define WDRC_PIN_RESET         8'haa

// Cause register bit positions
`define WDRC_CAUSE_PIN_FAULT   3
`define WDRC_CAUSE_VSEL_FAULT  1
`define WDRC_CAUSE_KEY_FAULT   0

// Status register bit positions
`define WDRC_STAT_TIMEOUT      0
`define WDRC_STAT_POWERDOWN    1

// Timing: watchdog clock is low-speed crystal divided by eight
`define WDRC_LXT_PRESCALE      8
`define WDRC_SYS_CLK_HZ        125000000
`define WDRC_LXT_HZ            32768
`define WDRC_FAULT_DELAY_NS    1000
`define WDRC_RELEASE_DELAY_NS  1000
`define WDRC_CLK_PERIOD_NS     8

`endif

// *** hw/wdrc_sync3.v ***
// Three-stage input synchroniser with agreement filter
`default_nettype none

module wdrc_sync3
(
    input  wire sys_clk_i,
    input  wire rst_i,
    input  wire rst_val_i,
    input  wire din_i,
    output reg  dout_o
);

    reg [2:0] stage_reg;

    // Shift chain; output follows once stages two and three agree
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stage_reg <= 3'h7;
            dout_o    <= 1'b1;
        end
        else
        begin
            stage_reg <= {stage_reg[1:0], din_i};
            if (stage_reg[1] == stage_reg[2])
                dout_o <= stage_reg[2];
        end
    end

endmodule

`default_nettype wire

// *** hw/wdrc_top.v ***
// Watchdog timer and reset control with Avalon-MM registers
`include "wdrc_defines.vh"
`default_nettype none

module wdrc_top
#(
    parameter FAULT_CYCLES   = (`WDRC_FAULT_DELAY_NS + `WDRC_CLK_PERIOD_NS - 1) / `WDRC_CLK_PERIOD_NS,
    parameter RELEASE_CYCLES = (`WDRC_RELEASE_DELAY_NS + `WDRC_CLK_PERIOD_NS - 1) / `WDRC_CLK_PERIOD_NS,
    parameter LXT_DIV        = `WDRC_SYS_CLK_HZ / `WDRC_LXT_HZ
)
(
    input  wire        sys_clk_i,
    input  wire        rst_i,
    // Avalon-MM slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // CPU events
    input  wire        clear_watchdog_instruction_i,
    input  wire        halt_exec_i,
    input  wire        low_power_mode_i,
    // Shared pin
    input  wire        shared_pin_i,
    input  wire        port_pin_func_sel_i,
    output reg         shared_port_bit_o,
    output reg         pin_is_reset_o,
    // Reset outputs
    output reg         device_reset_o,
    output reg         pc_sp_reset_o,
    output reg         port_preset_o,
    output reg         timeout_flag_o,
    output reg         powerdown_flag_o
);

    // -----------------------------------------------------------------
    // Local parameters
    // -----------------------------------------------------------------
    localparam [2:0] ST_RUN     = 3'b001;
    localparam [2:0] ST_HOLD    = 3'b010;
    localparam [2:0] ST_RELEASE = 3'b100;
    localparam       DCW        = 20;

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    reg  [7:0]     wdt_ctrl_reg;
    reg  [7:0]     pin_func_reg;
    reg            pin_fault_reg;
    reg            key_fault_reg;
    reg            vsel_fault_reg;
    reg  [2:0]     state_reg;
    reg  [DCW-1:0] delay_cnt_reg;
    reg  [DCW-1:0] fault_cnt_reg;
    reg            key_fault_pend_reg;
    reg            pin_fault_pend_reg;
    reg  [15:0]    lxt_cnt_reg;
    reg  [2:0]     pre_cnt_reg;
    reg  [17:0]    wdt_cnt_reg;
    reg            first_reg;
    reg            ack_reg;
    wire           pin_sync;
    wire           lxt_tick;
    wire           wdt_tick;
    wire           wdt_enabled;
    wire           pin_reset_sel;
    wire           pin_low;
    wire           overflow;
    wire           bus_req;
    wire           wr_ctrl;
    wire           wr_pin;
    wire           wr_cause;
    wire [17:0]    limit;

    // Key field decode, used for the fault check; enable compares the key directly
    function key_valid;
        input [4:0] key;
        begin
            key_valid = (key == `WDRC_KEY_ENABLE) || (key == `WDRC_KEY_DISABLE);
        end
    endfunction

    // Time-out limit from select field
    function [17:0] sel_limit;
        input [2:0] sel;
        begin
            case (sel)
                3'h0:    sel_limit = 18'h000ff;
                3'h1:    sel_limit = 18'h003ff;
                3'h2:    sel_limit = 18'h00fff;
                3'h3:    sel_limit = 18'h03fff;
                3'h4:    sel_limit = 18'h07fff;
                3'h5:    sel_limit = 18'h0ffff;
                3'h6:    sel_limit = 18'h1ffff;
                default: sel_limit = 18'h3ffff;
            endcase
        end
    endfunction

    // -----------------------------------------------------------------
    // Pin synchroniser and pin function
    // -----------------------------------------------------------------
    wdrc_sync3 u_pin_sync
    (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .rst_val_i (1'b1),
        .din_i     (shared_pin_i),
        .dout_o    (pin_sync)
    );

    assign pin_reset_sel = (pin_func_reg == `WDRC_PIN_RESET);
    assign pin_low       = pin_reset_sel && !pin_sync;
    assign wdt_enabled   = (wdt_ctrl_reg[`WDRC_KEY_MSB:`WDRC_KEY_LSB] == `WDRC_KEY_ENABLE);

    // Pin routing; reset selection wins over port muxing
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            shared_port_bit_o <= 1'b1;
            pin_is_reset_o    <= 1'b0;
        end
        else
        begin
            pin_is_reset_o    <= pin_reset_sel;
            shared_port_bit_o <= (pin_reset_sel || !port_pin_func_sel_i) ? 1'b1 : pin_sync;
        end
    end

    // -----------------------------------------------------------------
    // Watchdog clock: crystal rate, then divide by eight
    // -----------------------------------------------------------------
    assign lxt_tick = (lxt_cnt_reg == LXT_DIV[15:0] - 16'h1);
    assign wdt_tick = lxt_tick && (pre_cnt_reg == 3'h7);
    assign limit    = sel_limit(wdt_ctrl_reg[`WDRC_SEL_MSB:`WDRC_SEL_LSB]);
    assign overflow = wdt_enabled && wdt_tick && (wdt_cnt_reg == limit) && (state_reg == ST_RUN);

    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lxt_cnt_reg <= 16'h0;
            pre_cnt_reg <= 3'h0;
            wdt_cnt_reg <= 18'h0;
        end
        else
        begin
            lxt_cnt_reg <= lxt_tick ? 16'h0 : lxt_cnt_reg + 16'h1;
            if (lxt_tick)
                pre_cnt_reg <= pre_cnt_reg + 3'h1;
            if (key_fault_pend_reg || clear_watchdog_instruction_i || halt_exec_i || pin_low
                || overflow || !wdt_enabled || state_reg != ST_RUN)
                wdt_cnt_reg <= 18'h0;
            else if (wdt_tick)
                wdt_cnt_reg <= wdt_cnt_reg + 18'h1;
        end
    end

    // -----------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then acknowledge
    // -----------------------------------------------------------------
    assign bus_req  = (avs_read_i || avs_write_i) && !ack_reg;
    assign wr_ctrl  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == `WDRC_OFF_WDT_CTRL;
    assign wr_pin   = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == `WDRC_OFF_PIN_FUNC;
    assign wr_cause = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == `WDRC_OFF_CAUSE;

    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ack_reg           <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0;
        end
        else
        begin
            ack_reg           <= bus_req;
            avs_waitrequest_o <= !bus_req;
            if (bus_req && avs_read_i)
            begin
                case (avs_address_i)
                    `WDRC_OFF_WDT_CTRL: avs_readdata_o <= {24'h0, wdt_ctrl_reg};
                    `WDRC_OFF_PIN_FUNC: avs_readdata_o <= {24'h0, pin_func_reg};
                    `WDRC_OFF_CAUSE:    avs_readdata_o <= {28'h0, pin_fault_reg, 1'b0,
                                                           vsel_fault_reg, key_fault_reg};
                    `WDRC_OFF_STATUS:   avs_readdata_o <= {30'h0, powerdown_flag_o, timeout_flag_o};
                    default:            avs_readdata_o <= 32'h0;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Config registers and flags
    // -----------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_ctrl_reg   <= `WDRC_WDT_CTRL_RESET;
            pin_func_reg   <= `WDRC_PIN_PORT;
            pin_fault_reg  <= 1'b0;
            key_fault_reg  <= 1'b0;
            vsel_fault_reg <= 1'b0;
        end
        else
        begin
            // Full resets restore config once the pin lets go; warm reset leaves it
            if (device_reset_o && state_reg == ST_HOLD && !first_reg && !pin_low)
            begin
                wdt_ctrl_reg <= `WDRC_WDT_CTRL_RESET;
                pin_func_reg <= `WDRC_PIN_PORT;
            end
            else
            begin
                if (wr_ctrl)
                    wdt_ctrl_reg <= avs_writedata_i[7:0];
                if (wr_pin)
                    pin_func_reg <= avs_writedata_i[7:0];
            end
            // Set wins over software clear
            if (pin_fault_pend_reg && fault_cnt_reg == FAULT_CYCLES[DCW-1:0])
                pin_fault_reg <= 1'b1;
            else if (wr_cause && !avs_writedata_i[`WDRC_CAUSE_PIN_FAULT])
                pin_fault_reg <= 1'b0;
            if (key_fault_pend_reg && fault_cnt_reg == FAULT_CYCLES[DCW-1:0])
                key_fault_reg <= 1'b1;
            else if (wr_cause && !avs_writedata_i[`WDRC_CAUSE_KEY_FAULT])
                key_fault_reg <= 1'b0;
            if (wr_cause && !avs_writedata_i[`WDRC_CAUSE_VSEL_FAULT])
                vsel_fault_reg <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Config fault delay counters
    // -----------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            key_fault_pend_reg <= 1'b0;
            pin_fault_pend_reg <= 1'b0;
            fault_cnt_reg      <= {DCW{1'b0}};
        end
        else
        begin
            if (fault_cnt_reg == FAULT_CYCLES[DCW-1:0])
            begin
                key_fault_pend_reg <= 1'b0;
                pin_fault_pend_reg <= 1'b0;
                fault_cnt_reg      <= {DCW{1'b0}};
            end
            else if (key_fault_pend_reg || pin_fault_pend_reg)
                fault_cnt_reg <= fault_cnt_reg + {{(DCW-1){1'b0}}, 1'b1};
            else if (state_reg == ST_RUN) // Judge only settled config
            begin
                key_fault_pend_reg <= !key_valid(wdt_ctrl_reg[`WDRC_KEY_MSB:`WDRC_KEY_LSB]);
                pin_fault_pend_reg <= !(pin_func_reg == `WDRC_PIN_PORT || pin_reset_sel);
            end
        end
    end

    // -----------------------------------------------------------------
    // Reset sequencer: hold, then release delay
    // -----------------------------------------------------------------
    always @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg        <= ST_HOLD;
            first_reg        <= 1'b1;
            delay_cnt_reg    <= {DCW{1'b0}};
            device_reset_o   <= 1'b1;
            pc_sp_reset_o    <= 1'b1;
            port_preset_o    <= 1'b1;
            timeout_flag_o   <= 1'b0;
            powerdown_flag_o <= 1'b0;
        end
        else
        begin
            pc_sp_reset_o <= 1'b0;
            // Power-down and time-out flags
            if (halt_exec_i)
            begin
                powerdown_flag_o <= 1'b1;
                timeout_flag_o   <= 1'b0;
            end
            else if (clear_watchdog_instruction_i)
                powerdown_flag_o <= 1'b0;
            if (overflow)
                timeout_flag_o <= 1'b1;
            case (state_reg)
                ST_RUN:
                begin
                    if (overflow && low_power_mode_i)
                        pc_sp_reset_o <= 1'b1;
                    else if (overflow || pin_low || fault_cnt_reg == FAULT_CYCLES[DCW-1:0])
                    begin
                        state_reg      <= ST_HOLD;
                        device_reset_o <= 1'b1;
                        pc_sp_reset_o  <= 1'b1;
                    end
                end
                ST_HOLD:
                begin
                    device_reset_o <= 1'b1;
                    pc_sp_reset_o  <= 1'b1;
                    first_reg      <= 1'b0;
                    if (!pin_low)
                    begin
                        state_reg     <= ST_RELEASE;
                        delay_cnt_reg <= {DCW{1'b0}};
                    end
                end
                ST_RELEASE:
                begin
                    pc_sp_reset_o <= 1'b1;
                    if (pin_low)
                        state_reg <= ST_HOLD;
                    else if (delay_cnt_reg == RELEASE_CYCLES[DCW-1:0])
                    begin
                        state_reg      <= ST_RUN;
                        device_reset_o <= 1'b0;
                        port_preset_o  <= 1'b0;
                        pc_sp_reset_o  <= 1'b0;
                    end
                    else
                        delay_cnt_reg <= delay_cnt_reg + {{(DCW-1){1'b0}}, 1'b1};
                end
                default:
                    state_reg <= ST_HOLD;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** dv/wdrc_sva.sv ***
// Concurrent checks on the watchdog and reset control ports
`default_nettype none

module wdrc_sva
(
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        clear_watchdog_instruction_i,
    input wire logic        halt_exec_i,
    input wire logic        shared_pin_i,
    input wire logic        shared_port_bit_o,
    input wire logic        pin_is_reset_o,
    input wire logic        device_reset_o,
    input wire logic        pc_sp_reset_o,
    input wire logic        port_preset_o,
    input wire logic        timeout_flag_o,
    input wire logic        powerdown_flag_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Pin held low in reset mode past the synchroniser
    sequence s_pin_held_low;
        (pin_is_reset_o && !shared_pin_i)[*4];
    endsequence
    // Minimum hold of a full reset, small-parameter build
    sequence s_full_hold;
        device_reset_o[*4];
    endsequence

    property p_ack_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_ack_cause; $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i); endproperty
    property p_upper_zero; !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0; endproperty
    property p_pin_override; pin_is_reset_o |-> shared_port_bit_o; endproperty
    property p_pin_reset; s_pin_held_low |-> ##[0:4] device_reset_o; endproperty
    property p_release_hold; $rose(device_reset_o) |-> s_full_hold; endproperty
    property p_full_pcsp; device_reset_o |-> pc_sp_reset_o; endproperty
    property p_preset; port_preset_o |-> device_reset_o; endproperty
    property p_warm_flag; $rose(pc_sp_reset_o) && !device_reset_o |-> ##[0:2] timeout_flag_o; endproperty
    property p_halt_pd; halt_exec_i && !clear_watchdog_instruction_i |-> ##[1:2] powerdown_flag_o; endproperty
    property p_clear_pd; clear_watchdog_instruction_i && !halt_exec_i |-> ##[1:2] !powerdown_flag_o; endproperty

    a_ack_one: assert property (p_ack_one) else $error("wait release longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    a_pin_override: assert property (p_pin_override) else $error("port bit shown in reset mode");
    a_pin_reset: assert property (p_pin_reset) else $error("low pin gave no reset");
    a_release_hold: assert property (p_release_hold) else $error("reset released too early");
    a_full_pcsp: assert property (p_full_pcsp) else $error("full reset without pc reset");
    a_preset: assert property (p_preset) else $error("port preset outside reset");
    a_warm_flag: assert property (p_warm_flag) else $error("warm reset without flag");
    a_halt_pd: assert property (p_halt_pd) else $error("halt left powerdown low");
    a_clear_pd: assert property (p_clear_pd) else $error("clear left powerdown high");
endmodule

bind wdrc_top wdrc_sva u_sva
(
    .sys_clk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
    .clear_watchdog_instruction_i, .halt_exec_i, .shared_pin_i, .shared_port_bit_o, .pin_is_reset_o,
    .device_reset_o, .pc_sp_reset_o, .port_preset_o, .timeout_flag_o, .powerdown_flag_o
);

`default_nettype wire

// *** dv/wdrc_cpu_pin_model.sv ***
// Model of the software clear habit and the external reset pin circuit
`default_nettype none

module wdrc_cpu_pin_model
(
    input  wire logic sys_clk_i,
    input  wire logic kick_en_i,
    input  wire logic pin_low_i,
    output wire logic clear_o,
    output wire logic pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] cnt_reg   = 10'h0;
    logic       clear_reg = 1'b0;

    // Pull-up keeps the pin high unless the circuit pulls it down
    assign pin_o   = pin_low_i ? 1'b0 : 1'b1;
    assign clear_o = clear_reg;

    // One clear instruction every 1024 cycles, inside the shortest period
    always @(posedge sys_clk_i)
    begin
        cnt_reg   <= cnt_reg + 10'h1;
        clear_reg <= kick_en_i && (cnt_reg == 10'h0);
    end
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking testbench for the watchdog and reset control block
`include "wdrc_defines.vh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, rst_i, avs_read_i, avs_write_i, halt_exec_i, low_power_mode_i;
    logic        port_pin_func_sel_i, avs_waitrequest_o, shared_port_bit_o, pin_is_reset_o;
    logic        device_reset_o, pc_sp_reset_o, port_preset_o, timeout_flag_o, powerdown_flag_o;
    logic        clr_pulse, pin_line, kick_en, pin_low;
    logic [3:0]  avs_address_i, avs_byteenable_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rdv;
    int          error_cnt, n_compared, rst_rises, n, r0;

    wdrc_top #(.FAULT_CYCLES(4), .RELEASE_CYCLES(4), .LXT_DIV(4)) dut
    (
        .sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .clear_watchdog_instruction_i(clr_pulse), .halt_exec_i, .low_power_mode_i,
        .shared_pin_i(pin_line), .port_pin_func_sel_i, .shared_port_bit_o, .pin_is_reset_o,
        .device_reset_o, .pc_sp_reset_o, .port_preset_o, .timeout_flag_o, .powerdown_flag_o
    );
    wdrc_cpu_pin_model u_far (.sys_clk_i, .kick_en_i(kick_en), .pin_low_i(pin_low), .clear_o(clr_pulse),
                              .pin_o(pin_line));

    // Clock and reset-event counter
    initial
    begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge device_reset_o) rst_rises++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd, input logic [3:0] be);
        int k;
        k = 0;
        avs_address_i    <= a;
        avs_write_i      <= wr;
        avs_read_i       <= !wr;
        avs_writedata_i  <= {24'h0, wd};
        avs_byteenable_i <= be;
        do
        begin
            @(posedge sys_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 100);
        if (k >= 100) chk(32'h0, 32'h1);
        rdv = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'h1);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h0, 4'h1);
        chk(rdv, exp);
    endtask

    // Bounded wait for a level; reports the cycles waited and checks the level
    task automatic wait_sig(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s !== v && k < lim)
        begin
            @(posedge sys_clk_i);
            k++;
        end
        chk(s, v);
    endtask

    task automatic pulse_halt();
        halt_exec_i <= 1'b1;
        @(posedge sys_clk_i);
        halt_exec_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard, about twice the expected run
    initial
    begin
        #600000;
        error_cnt++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        {rst_i, avs_read_i, avs_write_i, halt_exec_i, low_power_mode_i, port_pin_func_sel_i} = 6'h20;
        {avs_address_i, avs_byteenable_i, avs_writedata_i, kick_en, pin_low} = '0;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        chk(port_preset_o, 1'b1);
        wait_sig(device_reset_o, 1'b0, 100, n);
        chk(port_preset_o, 1'b0);
        rd_chk(`WDRC_OFF_WDT_CTRL, 32'h52);
        rd_chk(`WDRC_OFF_PIN_FUNC, 32'h55);
        rd_chk(`WDRC_OFF_CAUSE, 32'h0);
        wr(4'h1, 8'hff);
        rd_chk(4'h1, 32'h0);
        bus(1'b1, `WDRC_OFF_WDT_CTRL, 8'h00, 4'he);
        rd_chk(`WDRC_OFF_WDT_CTRL, 32'h52);
        // Port mode: pin level reaches the port bit, no reset
        pin_low <= 1'b1;
        port_pin_func_sel_i <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        chk({pin_is_reset_o, shared_port_bit_o, device_reset_o}, 3'h0);
        pin_low <= 1'b0;
        port_pin_func_sel_i <= 1'b0;
        // Shortest period, kept alive by periodic clears
        wr(`WDRC_OFF_WDT_CTRL, 8'h50);
        kick_en <= 1'b1;
        r0 = rst_rises;
        repeat (12000) @(posedge sys_clk_i);
        chk(rst_rises, r0);
        pulse_halt();
        chk(powerdown_flag_o, 1'b1);
        wait_sig(powerdown_flag_o, 1'b0, 1100, n);
        // Disabled watchdog never fires
        wr(`WDRC_OFF_WDT_CTRL, 8'ha8);
        kick_en <= 1'b0;
        repeat (10000) @(posedge sys_clk_i);
        chk(rst_rises, r0);
        // Enabled, cleared by halt, then overflow after 2^8 ticks of LXT_DIV*8 cycles
        wr(`WDRC_OFF_WDT_CTRL, 8'h50);
        pulse_halt();
        wait_sig(device_reset_o, 1'b1, 9000, n);
        chk(n >= 8000 && n <= 8400, 1'b1);
        wait_sig(device_reset_o, 1'b0, 100, n);
        chk(timeout_flag_o, 1'b1);
        // Timeout in low-power mode: warm reset keeps configuration
        wr(`WDRC_OFF_WDT_CTRL, 8'h50);
        wr(`WDRC_OFF_PIN_FUNC, 8'haa);
        low_power_mode_i <= 1'b1;
        pulse_halt();
        wait_sig(pc_sp_reset_o, 1'b1, 9000, n);
        chk({device_reset_o, timeout_flag_o}, 2'h1);
        rd_chk(`WDRC_OFF_STATUS, 32'h3);
        low_power_mode_i <= 1'b0;
        kick_en <= 1'b1;
        rd_chk(`WDRC_OFF_PIN_FUNC, 32'haa);
        rd_chk(`WDRC_OFF_WDT_CTRL, 32'h50);
        // Reset pin mode overrides the other pin-share select
        port_pin_func_sel_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk({pin_is_reset_o, shared_port_bit_o}, 2'h3);
        pin_low <= 1'b1;
        wait_sig(device_reset_o, 1'b1, 20, n);
        repeat (20) @(posedge sys_clk_i);
        chk(device_reset_o, 1'b1);
        pin_low <= 1'b0;
        wait_sig(device_reset_o, 1'b0, 50, n);
        chk(n >= 4, 1'b1);
        rd_chk(`WDRC_OFF_PIN_FUNC, 32'h55);
        port_pin_func_sel_i <= 1'b0;
        // Invalid key: delayed reset, key fault flag, cleared by zero
        wr(`WDRC_OFF_WDT_CTRL, 8'h00);
        wait_sig(device_reset_o, 1'b1, 30, n);
        wait_sig(device_reset_o, 1'b0, 50, n);
        rd_chk(`WDRC_OFF_CAUSE, 32'h01);
        rd_chk(`WDRC_OFF_WDT_CTRL, 32'h52);
        wr(`WDRC_OFF_CAUSE, 8'h00);
        rd_chk(`WDRC_OFF_CAUSE, 32'h0);
        // Invalid pin function: reset and pin fault flag
        wr(`WDRC_OFF_PIN_FUNC, 8'h12);
        wait_sig(device_reset_o, 1'b1, 30, n);
        wait_sig(device_reset_o, 1'b0, 50, n);
        rd_chk(`WDRC_OFF_CAUSE, 32'h08);
        wr(`WDRC_OFF_CAUSE, 8'h08);
        rd_chk(`WDRC_OFF_CAUSE, 32'h08);
        wr(`WDRC_OFF_CAUSE, 8'h00);
        rd_chk(`WDRC_OFF_CAUSE, 32'h0);
        print_verdict();
    end
endmodule

`default_nettype wire
